// File: hw/ipcl_consts.svh
// constants: register indices, field positions, reset values and timing
`ifndef IPCL_CONSTS_SVH
`define IPCL_CONSTS_SVH

`define IPCL_IDX_ELEC 10'h053
`define IPCL_IDX_HOLD 10'h054
`define IPCL_IDX_LCLR 10'h060
`define IPCL_IDX_STAT 10'h061
`define IPCL_IDX_SCLR 10'h062
`define IPCL_IDX_IEN 10'h063

`define IPCL_ELEC_DRV 3
`define IPCL_ELEC_OD 2
`define IPCL_ELEC_POL 1
`define IPCL_ELEC_EDGE 0
`define IPCL_ELEC_PIN_B_SHIFT 4
`define IPCL_HOLD_IN_EN_A 4
`define IPCL_HOLD_RSV_MASK 8'h3f
`define IPCL_LCLR_BIT 0

`define IPCL_ELEC_RST 8'h00
`define IPCL_HOLD_RST 8'h00
`define IPCL_MODE_NONLATCH 4'h0
`define IPCL_MODE_LATCH 4'hf

`define IPCL_ST_FIRE_A 0
`define IPCL_ST_TRIG_A 2
`define IPCL_ST_W 4

`define IPCL_CLK_MHZ 40
`define IPCL_HOLD_BASE_NS 312500
`define IPCL_HOLD_BASE_CYC ((`IPCL_HOLD_BASE_NS * `IPCL_CLK_MHZ) / 1000)

`endif

// File: hw/ipcl_pkg.sv
// package: types shared by the interrupt pin control block
package ipcl_pkg;
    typedef enum logic [1:0] {HS_IDLE, HS_TIMED, HS_LATCHED} ipcl_hold_e;
    typedef logic [7:0] ipcl_reg_t;
endpackage

// File: hw/ipcl_hold.sv
// hold engine: non-latched, temporary and latched interrupt hold per pin
`timescale 1ns/100ps
`include "ipcl_consts.svh"
module ipcl_hold #(
    parameter int BASE_CYC = `IPCL_HOLD_BASE_CYC,
    parameter int CNT_W = 27
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] mode,
    input wire logic latch_clr,
    input wire logic src,
    output logic held_o,
    output logic fire_o
);
    ipcl_pkg::ipcl_hold_e state_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] dur;
    logic src_d_r;
    logic fire_r;
    logic rise;

    assign rise = src & ~src_d_r;
    // duration doubles with each code step above the base
    assign dur = CNT_W'(BASE_CYC) << (mode - 4'h1);
    assign held_o = src | (state_r != ipcl_pkg::HS_IDLE);
    assign fire_o = fire_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            src_d_r <= 1'b0;
            fire_r <= 1'b0;
        end else begin
            src_d_r <= src;
            fire_r <= rise;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ipcl_pkg::HS_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                ipcl_pkg::HS_IDLE: begin
                    if (rise && mode == `IPCL_MODE_LATCH) begin
                        state_r <= ipcl_pkg::HS_LATCHED;
                    end else if (rise && mode != `IPCL_MODE_NONLATCH) begin
                        state_r <= ipcl_pkg::HS_TIMED;
                        cnt_r <= dur;
                    end
                end
                ipcl_pkg::HS_TIMED: begin
                    if (mode == `IPCL_MODE_NONLATCH) begin
                        state_r <= ipcl_pkg::HS_IDLE;
                    end else if (rise && mode == `IPCL_MODE_LATCH) begin
                        state_r <= ipcl_pkg::HS_LATCHED;
                    end else if (rise) begin
                        cnt_r <= dur;
                    end else if (cnt_r <= CNT_W'(1)) begin
                        state_r <= ipcl_pkg::HS_IDLE;
                    end else begin
                        cnt_r <= cnt_r - CNT_W'(1);
                    end
                end
                ipcl_pkg::HS_LATCHED: begin
                    // a new event in the clearing cycle keeps the latch
                    if (mode == `IPCL_MODE_NONLATCH) begin
                        state_r <= ipcl_pkg::HS_IDLE;
                    end else if (latch_clr && !rise) begin
                        state_r <= ipcl_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state_r <= ipcl_pkg::HS_IDLE;
                end
            endcase
        end
    end

    AST_NONLATCH_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mode == `IPCL_MODE_NONLATCH |=> state_r == ipcl_pkg::HS_IDLE)
        else $error("hold engine active in non-latched mode");
    AST_LATCH_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ipcl_pkg::HS_LATCHED && !latch_clr &&
        mode != `IPCL_MODE_NONLATCH |=> state_r == ipcl_pkg::HS_LATCHED)
        else $error("latched interrupt released without clear");
    AST_TIMED_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r != ipcl_pkg::HS_LATCHED &&
        rise && mode != `IPCL_MODE_NONLATCH && mode != `IPCL_MODE_LATCH
        |=> state_r == ipcl_pkg::HS_TIMED && cnt_r == $past(dur))
        else $error("temporary hold not loaded with its duration");
    AST_TIMED_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ipcl_pkg::HS_TIMED && cnt_r == CNT_W'(1) && !rise
        |=> state_r == ipcl_pkg::HS_IDLE)
        else $error("temporary hold not released at end of duration");
    AST_LATCH_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ipcl_pkg::HS_LATCHED && latch_clr && !rise
        |=> state_r == ipcl_pkg::HS_IDLE ##1 (!held_o || src || $past(rise)))
        else $error("latched interrupt not released by clear");
endmodule

// File: hw/ipcl_top.sv
// top: interrupt pin electrical control, hold modes and apb registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "ipcl_consts.svh"
// Operation
// - per-pin drive enable bit switches output driver
// - per-pin bit selects push-pull or open-drain
// - polarity governs output, else power trigger input
// - queue tagging ignores the pin polarity
// - per-pin bit selects edge or level input
// - per-pin input enables; bits 7:6 reserved
// - mode code 0 non-latched, 15 latched
// - temporary holds from 312.5 us doubling
// - direct interrupts bypass every hold mode
// - both control registers reset to zero
module ipcl_top #(
    parameter int HOLD_BASE_CYC = `IPCL_HOLD_BASE_CYC,
    parameter int HOLD_CNT_W = 27
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_pin_a_held_src,
    input wire logic irq_pin_a_direct_src,
    input wire logic irq_pin_a_i,
    input wire logic queue_tag_pin_a_enable,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe,
    output logic pin_a_power_trigger,
    output logic pin_a_queue_tag,
    input wire logic irq_pin_b_held_src,
    input wire logic irq_pin_b_direct_src,
    input wire logic irq_pin_b_i,
    input wire logic queue_tag_pin_b_enable,
    output logic irq_pin_b_o,
    output logic irq_pin_b_oe,
    output logic pin_b_power_trigger,
    output logic pin_b_queue_tag,
    output logic irq_o
);
    ipcl_pkg::ipcl_reg_t elec_r;
    ipcl_pkg::ipcl_reg_t hold_r;
    logic [`IPCL_ST_W-1:0] stat_r;
    logic [`IPCL_ST_W-1:0] ien_r;
    logic [`IPCL_ST_W-1:0] sclr;
    logic [`IPCL_ST_W-1:0] events;
    logic [31:0] prdata_r;
    logic [31:0] rd_val;
    logic [9:0] idx;
    logic hit;
    logic wr_acc;
    logic latch_clr;

    logic [1:0] drv_en;
    logic [1:0] od_sel;
    logic [1:0] pol;
    logic [1:0] edge_sel;
    logic [1:0] in_en;
    logic [1:0] held_src;
    logic [1:0] direct_src;
    logic [1:0] pin_i;
    logic [1:0] tag_en;
    logic [1:0] held;
    logic [1:0] fire;
    logic [1:0] asserted;
    logic [1:0] lvl;
    logic [1:0] act;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] act_prev_r;
    logic [1:0] trig_r;
    logic [1:0] tag_r;
    logic [1:0] pin_o_r;
    logic [1:0] pin_oe_r;

    assign held_src = {irq_pin_b_held_src, irq_pin_a_held_src};
    assign direct_src = {irq_pin_b_direct_src, irq_pin_a_direct_src};
    assign pin_i = {irq_pin_b_i, irq_pin_a_i};
    assign tag_en = {queue_tag_pin_b_enable, queue_tag_pin_a_enable};

    // apb slave: zero wait states, read data captured in the setup cycle
    assign idx = paddr[11:2];
    assign pready = 1'b1;
    assign wr_acc = psel & penable & pwrite & hit;
    assign pslverr = psel & penable & ~hit;
    assign prdata = prdata_r;
    assign latch_clr = wr_acc & (idx == `IPCL_IDX_LCLR) & pstrb[0] &
        pwdata[`IPCL_LCLR_BIT];
    assign sclr = (wr_acc && idx == `IPCL_IDX_SCLR && pstrb[0]) ?
        pwdata[`IPCL_ST_W-1:0] : '0;

    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        case (idx)
            `IPCL_IDX_ELEC: begin
                rd_val = {24'h00_0000, elec_r};
            end
            `IPCL_IDX_HOLD: begin
                rd_val = {24'h00_0000, hold_r & `IPCL_HOLD_RSV_MASK};
            end
            `IPCL_IDX_STAT: begin
                rd_val = {28'h000_0000, stat_r};
            end
            `IPCL_IDX_IEN: begin
                rd_val = {28'h000_0000, ien_r};
            end
            `IPCL_IDX_LCLR, `IPCL_IDX_SCLR: begin
                rd_val = 32'h0000_0000;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_r <= rd_val;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            elec_r <= `IPCL_ELEC_RST;
            hold_r <= `IPCL_HOLD_RST;
            ien_r <= '0;
        end else if (wr_acc && pstrb[0]) begin
            if (idx == `IPCL_IDX_ELEC) begin
                elec_r <= pwdata[7:0];
            end
            if (idx == `IPCL_IDX_HOLD) begin
                hold_r <= pwdata[7:0] & `IPCL_HOLD_RSV_MASK;
            end
            if (idx == `IPCL_IDX_IEN) begin
                ien_r <= pwdata[`IPCL_ST_W-1:0];
            end
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    assign events = {trig_r, fire};
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~sclr) | events;
        end
    end
    assign irq_o = |(stat_r & ien_r);

    // field extraction, electrical fields pin a in the low nibble, pin b in the high one; input enables at hold bits 4 and 5
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            drv_en[i] = elec_r[`IPCL_ELEC_PIN_B_SHIFT * i + `IPCL_ELEC_DRV];
            od_sel[i] = elec_r[`IPCL_ELEC_PIN_B_SHIFT * i + `IPCL_ELEC_OD];
            pol[i] = elec_r[`IPCL_ELEC_PIN_B_SHIFT * i + `IPCL_ELEC_POL];
            edge_sel[i] = elec_r[`IPCL_ELEC_PIN_B_SHIFT * i + `IPCL_ELEC_EDGE];
            in_en[i] = hold_r[`IPCL_HOLD_IN_EN_A + i];
        end
    end

    ipcl_hold #(
        .BASE_CYC(HOLD_BASE_CYC),
        .CNT_W(HOLD_CNT_W)
    ) u_hold_a (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mode(hold_r[3:0]),
        .latch_clr(latch_clr),
        .src(held_src[0]),
        .held_o(held[0]),
        .fire_o(fire[0])
    );

    ipcl_hold #(
        .BASE_CYC(HOLD_BASE_CYC),
        .CNT_W(HOLD_CNT_W)
    ) u_hold_b (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .mode(hold_r[3:0]),
        .latch_clr(latch_clr),
        .src(held_src[1]),
        .held_o(held[1]),
        .fire_o(fire[1])
    );

    // output stage: direct sources never pass the hold engine
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            asserted[i] = held[i] | direct_src[i];
            lvl[i] = pol[i] ? asserted[i] : ~asserted[i];
        end
    end

    // open drain only ever pulls low; high comes from the board pull-up
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_o_r <= 2'h0;
            pin_oe_r <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pin_o_r[i] <= od_sel[i] ? 1'b0 : lvl[i];
                pin_oe_r[i] <= drv_en[i] & (od_sel[i] ? ~lvl[i] : 1'b1);
            end
        end
    end

    // pin inputs cross from the board, two flops before use
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end

    // polarity only shapes the trigger while the driver is off
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            act[i] = (drv_en[i] || pol[i]) ? sync2_r[i] : ~sync2_r[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            act_prev_r <= 2'h0;
            trig_r <= 2'h0;
            tag_r <= 2'h0;
        end else begin
            act_prev_r <= act;
            for (int i = 0; i < 2; i++) begin
                trig_r[i] <= in_en[i] & (edge_sel[i] ?
                    (act[i] & ~act_prev_r[i]) : act[i]);
                tag_r[i] <= in_en[i] & tag_en[i] & sync2_r[i];
            end
        end
    end

    assign irq_pin_a_o = pin_o_r[0];
    assign irq_pin_a_oe = pin_oe_r[0];
    assign irq_pin_b_o = pin_o_r[1];
    assign irq_pin_b_oe = pin_oe_r[1];
    assign pin_a_power_trigger = trig_r[0];
    assign pin_b_power_trigger = trig_r[1];
    assign pin_a_queue_tag = tag_r[0];
    assign pin_b_queue_tag = tag_r[1];

    AST_RESET_VALUES: assert property (@(posedge sys_clk)
        !rst_n |=> elec_r == 8'h00 && hold_r == 8'h00 && pin_oe_r == 2'h0)
        else $error("control registers not zero after reset");

    AST_STAT_SET_WINS: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        |(events & sclr)
        |=> (stat_r & $past(events & sclr)) == $past(events & sclr))
        else $error("status event lost against clear");

    AST_STAT_CLEAR: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        (events & sclr) == '0
        |=> (stat_r & $past(sclr)) == '0)
        else $error("status bit survived its clear");

    // byte lane 0 carries every field, so without it nothing may change
    AST_STRB_IGNORED: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && pwrite && !pstrb[0]
        |=> $stable(elec_r) && $stable(hold_r) && $stable(ien_r))
        else $error("write without byte lane 0 changed a register");

    AST_ELEC_WRITE: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_acc && pstrb[0] && idx == `IPCL_IDX_ELEC
        |=> elec_r == $past(pwdata[7:0]))
        else $error("electrical control write not stored");

    AST_RSV_DROPPED: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        wr_acc && pstrb[0] && idx == `IPCL_IDX_HOLD
        |=> hold_r == ($past(pwdata[7:0]) & `IPCL_HOLD_RSV_MASK))
        else $error("hold control write kept reserved bits");

    AST_UNMAPPED_ERR: assert property (@(posedge sys_clk)
        disable iff (!rst_n)
        psel && penable && !hit
        |-> pslverr && prdata == 32'h0000_0000 && !wr_acc)
        else $error("unmapped access not refused");

    for (genvar gi = 0; gi < 2; gi++) begin : g_chk
        AST_DRIVE_OFF: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            !drv_en[gi] |=> !pin_oe_r[gi])
            else $error("pin driven while its driver is disabled");
        AST_OPEN_DRAIN: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            drv_en[gi] && od_sel[gi]
            |=> !pin_o_r[gi] && (pin_oe_r[gi] == !$past(lvl[gi])))
            else $error("open drain pin drove a high level");
        AST_POLARITY: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            drv_en[gi] && !od_sel[gi] && held[gi]
            |=> pin_oe_r[gi] && pin_o_r[gi] == $past(pol[gi]))
            else $error("asserted push-pull level ignores polarity");
        AST_TAG_RAW: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            in_en[gi] && tag_en[gi] |=> tag_r[gi] == $past(sync2_r[gi]))
            else $error("queue tag depends on polarity");
        AST_EDGE_PULSE: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            $past(edge_sel[gi]) && edge_sel[gi] && trig_r[gi]
            |=> !trig_r[gi])
            else $error("edge trigger longer than one cycle");
        AST_INPUT_OFF: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            !in_en[gi] |=> !trig_r[gi] && !tag_r[gi])
            else $error("disabled input produced a trigger or tag");
        AST_DIRECT_PASS: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            direct_src[gi] && drv_en[gi] && !od_sel[gi]
            |=> pin_o_r[gi] == $past(pol[gi]))
            else $error("direct interrupt did not reach the pin");
        AST_TRIG_LEVEL: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            in_en[gi] && !edge_sel[gi] && !drv_en[gi]
            |=> trig_r[gi] == ($past(sync2_r[gi]) == $past(pol[gi])))
            else $error("level trigger ignores polarity");
        AST_PUSH_PULL_IDLE: assert property (@(posedge sys_clk)
            disable iff (!rst_n)
            drv_en[gi] && !od_sel[gi] && !held[gi] && !direct_src[gi]
            |=> pin_oe_r[gi] && pin_o_r[gi] == !$past(pol[gi]))
            else $error("idle push-pull level ignores polarity");
    end
endmodule

// File: sim/ipcl_host.sv
// host side model of one interrupt line, with its pull-up
`timescale 1ns/100ps
module ipcl_host (
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic host_drive,
    input wire logic host_val,
    output logic line
);
    // pull-up gives the released open-drain line its idle level
    always_comb begin
        if (pin_oe && host_drive)
            line = pin_o & host_val;
        else if (pin_oe)
            line = pin_o;
        else if (host_drive)
            line = host_val;
        else
            line = 1'b1;
    end
endmodule

// File: sim/tb_interrupt_pin_control_latch.sv
// testbench: pin drive, hold modes, pin inputs and registers
`timescale 1ns/100ps
module tb_interrupt_pin_control_latch;
    localparam int BASE = 4;
    logic sys_clk, rst_n, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, q;
    logic [3:0] pstrb, strb;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq_o;
    logic [1:0] hsrc, dsrc, tagen, hdrv, hval;
    wire logic [1:0] lvl, po, poe, ptrig, ptag;
    logic e;
    int n_errors, samples_checked;

    ipcl_top #(.HOLD_BASE_CYC(BASE)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pin_a_held_src(hsrc[0]),
        .irq_pin_a_direct_src(dsrc[0]), .irq_pin_a_i(lvl[0]),
        .queue_tag_pin_a_enable(tagen[0]), .irq_pin_a_o(po[0]),
        .irq_pin_a_oe(poe[0]), .pin_a_power_trigger(ptrig[0]),
        .pin_a_queue_tag(ptag[0]), .irq_pin_b_held_src(hsrc[1]),
        .irq_pin_b_direct_src(dsrc[1]), .irq_pin_b_i(lvl[1]),
        .queue_tag_pin_b_enable(tagen[1]), .irq_pin_b_o(po[1]),
        .irq_pin_b_oe(poe[1]), .pin_b_power_trigger(ptrig[1]),
        .pin_b_queue_tag(ptag[1]), .irq_o(irq_o));
    ipcl_host host_a (.pin_o(po[0]), .pin_oe(poe[0]), .host_drive(hdrv[0]),
        .host_val(hval[0]), .line(lvl[0]));
    ipcl_host host_b (.pin_o(po[1]), .pin_oe(poe[1]), .host_drive(hdrv[1]),
        .host_val(hval[1]), .line(lvl[1]));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task print_verdict;
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // waits n edges, then lets that edge's updates settle
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
            input logic [31:0] d, output logic [31:0] rq, output logic re);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= strb;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && k < 16) begin
            k++;
            @(posedge sys_clk);
        end
        if (k == 16)
            chk(pready, 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, q, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, q, e);
        chk(q, exp);
    endtask

    task automatic pulse_held(input int p);
        @(posedge sys_clk);
        hsrc[p] <= 1'b1;
        @(posedge sys_clk);
        hsrc[p] <= 1'b0;
    endtask

    task automatic t_regs;
        chk(poe, 2'b00);
        chk(pready, 1'b1);
        rdc(12'h14c, 32'h0);
        rdc(12'h150, 32'h0);
        wr(12'h14c, 32'ha5);
        strb = 4'h0;
        wr(12'h14c, 32'h0);
        strb = 4'hf;
        rdc(12'h14c, 32'ha5);
        wr(12'h150, 32'hff);
        rdc(12'h150, 32'h3f);
        wr(12'h150, 32'h0);
        wr(12'h14c, 32'h0);
        apb(12'h000, 1'b0, 32'h0, q, e);
        chk(e, 1'b1);
        chk(q, 32'h0);
    endtask

    // every push-pull/open-drain and polarity pairing with the driver on, then driver off; mode non-latched
    task automatic t_output(input int p);
        logic [3:0] f;
        for (int c = 0; c < 4; c++) begin
            f = {1'b1, c[1], c[0], 1'b0};
            wr(12'h14c, 32'(f) << (4 * p));
            @(posedge sys_clk);
            hsrc[p] <= 1'b1;
            wt(3);
            chk(lvl[p], c[0]);
            chk(poe[p], c[1] ? !c[0] : 1'b1);
            @(posedge sys_clk);
            hsrc[p] <= 1'b0;
            wt(3);
            chk(lvl[p], !c[0]);
            chk(poe[p], c[1] ? c[0] : 1'b1);
        end
        wr(12'h14c, 32'h0);
        @(posedge sys_clk);
        hsrc[p] <= 1'b1;
        wt(3);
        chk(poe[p], 1'b0);
        @(posedge sys_clk);
        hsrc[p] <= 1'b0;
    endtask

    task automatic t_timed;
        int n;
        wr(12'h14c, 32'h0a);
        for (int m = 1; m < 4; m++) begin
            n = BASE << (m - 1);
            wr(12'h150, 32'(m));
            pulse_held(0);
            wt(n - 1);
            chk(lvl[0], 1'b1);
            wt(6);
            chk(lvl[0], 1'b0);
        end
    endtask

    task automatic t_latch;
        wr(12'h150, 32'hf);
        @(posedge sys_clk);
        dsrc[0] <= 1'b1;
        @(posedge sys_clk);
        dsrc[0] <= 1'b0;
        wt(3);
        chk(lvl[0], 1'b0);
        pulse_held(0);
        wt(40);
        chk(lvl[0], 1'b1);
        wr(12'h180, 32'h1);
        wt(3);
        chk(lvl[0], 1'b0);
        wr(12'h150, 32'h0);
        wr(12'h14c, 32'h0);
    endtask

    // pin as input; the host drives the line
    task automatic t_input(input int p);
        logic [31:0] cnt;
        wr(12'h14c, 32'h2 << (4 * p));
        wr(12'h150, 32'h10 << p);
        @(posedge sys_clk);
        tagen[p] <= 1'b1;
        hdrv[p] <= 1'b1;
        hval[p] <= 1'b1;
        wt(5);
        chk(ptrig[p], 1'b1);
        chk(ptag[p], 1'b1);
        wr(12'h188, 32'hf);
        rdc(12'h184, 32'h4 << p);
        wr(12'h14c, 32'h0);
        wt(5);
        chk(ptrig[p], 1'b0);
        chk(ptag[p], 1'b1);
        wr(12'h14c, 32'h3 << (4 * p));
        @(posedge sys_clk);
        hval[p] <= 1'b0;
        wt(5);
        @(posedge sys_clk);
        hval[p] <= 1'b1;
        cnt = 0;
        repeat (8) begin
            wt(1);
            cnt = cnt + ptrig[p];
        end
        chk(cnt, 32'h1);
        wr(12'h150, 32'h0);
        wt(4);
        chk(ptag[p], 1'b0);
        @(posedge sys_clk);
        hdrv[p] <= 1'b0;
        tagen[p] <= 1'b0;
        wr(12'h14c, 32'h0);
    endtask

    // status is sticky; earlier scenarios left bits set, so clear first
    task automatic t_irq;
        wr(12'h188, 32'hf);
        wr(12'h18c, 32'h0);
        pulse_held(0);
        wt(3);
        rdc(12'h184, 32'h1);
        chk(irq_o, 1'b0);
        wr(12'h18c, 32'h1);
        wt(1);
        chk(irq_o, 1'b1);
        wr(12'h188, 32'h1);
        wt(1);
        chk(irq_o, 1'b0);
        rdc(12'h184, 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hf;
        strb = 4'hf;
        {hsrc, dsrc, tagen, hdrv, hval} = '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        wt(2);
        t_regs();
        t_output(0);
        t_output(1);
        t_timed();
        t_latch();
        t_input(0);
        t_input(1);
        t_irq();
        print_verdict();
    end
endmodule
